//--- core/dfr_defs.svh
// Purpose: Constants for the digital input function router
// Assumes: Avalon byte addresses, one 32-bit word per register
// Notes:   Plain decimal function codes also index hit vectors
`ifndef DFR_DEFS_SVH
`define DFR_DEFS_SVH

// ==========================================
// Register byte offsets
`define DFR_OFS_SEL0     6'h00
`define DFR_OFS_AUTO     6'h20
`define DFR_OFS_PINS     6'h24
`define DFR_OFS_CMD      6'h28

// ==========================================
// Reset values
`define DFR_SEL_RST0     6'h01
`define DFR_SEL_RST1     6'h02
`define DFR_SEL_RST2     6'h05
`define DFR_SEL_RST3     6'h06
`define DFR_SEL_RST4     6'h07
`define DFR_SEL_RST5     6'h08
`define DFR_SEL_RSTX     6'h00
`define DFR_AUTO_RST     1'h0

// ==========================================
// Selector range and timing
`define DFR_CODE_MAX     6'h20
`define DFR_SETTLE_CYC   3'h4

// ==========================================
// Function codes
`define DFR_C_FWD        1
`define DFR_C_REV        2
`define DFR_C_EN_HI      3
`define DFR_C_EN_LO      4
`define DFR_C_FRST       5
`define DFR_C_STEP0      6
`define DFR_C_STEP1      7
`define DFR_C_STEP2      8
`define DFR_C_STEP3      9
`define DFR_C_HOOK       10
`define DFR_C_DIR        11
`define DFR_C_REM_HI     12
`define DFR_C_LOC_LO     13
`define DFR_C_REM2_HI    14
`define DFR_C_REM_LO     15
`define DFR_C_FOLLOW     16
`define DFR_C_MSEL0      17
`define DFR_C_MSEL1      18
`define DFR_C_PASSIVE    19
`define DFR_C_MAINS      20
`define DFR_C_BRAKE      22
`define DFR_C_COAST      24
`define DFR_C_FORCE      26
`define DFR_C_TZERO      28

`endif

//--- core/dfr_pkg.sv
// Purpose: Types shared by the input router
// Assumes: Codes and offsets live in dfr_defs.svh
// Notes:   Command word is 21 bits, read back at the command offset
package dfr_pkg;

    // ==========================================
    // Selector code type
    typedef logic [5:0] dfr_sel_t;

    // ==========================================
    // Internal command bundle
    typedef struct packed {
        logic       run_fwd;            // Forward run
        logic       run_rev;            // Reverse run
        logic       drive_enable;       // Drive enable
        logic       fault_reset;        // Fault reset request
        logic [3:0] speed_step;         // Multi-step speed index
        logic       hook_mode;          // Hook mode
        logic       dir_switch;         // Direction reversal
        logic       estop_remote;       // Remote emergency stop
        logic       estop_local;        // Local emergency stop
        logic       follower_ready;     // Parallel follower ready
        logic [1:0] motor_sel;          // Motor selection
        logic       pt_inhibit;         // Power transistor inhibit
        logic       mains_confirm;      // Mains contactor closed
        logic       brake_feedback;     // Brake contact feedback
        logic       free_run_stop;      // Coasting stop
        logic       force_control;      // Torque mode when set
        logic       torque_zero;        // Torque setpoint forced to zero
    } dfr_cmd_t;

endpackage

//--- core/dfr_router.sv
// Purpose: Route eight digital input terminals onto drive commands
// Assumes: Avalon-MM slave, one clock, synchronous active-high reset
// Notes:   Terminals pass three sync flops and a filter flop; commands are registered
//
// Contract
// - Eight selectors, codes 0..32, fixed defaults
// - Code 0 drives no command
// - Codes 1/2 forward and reverse run
// - Code 3 enable when input high
// - Code 4 enable when input low
// - Code 5 requests fault reset
// - Codes 6..9 give speed bits 0..3
// - Code 10 hook mode while on
// - Code 11 reverses direction while on
// - Codes 12, 14 emergency on high
// - Codes 13, 15 emergency on low
// - Code 16 passes follower ready
// - Codes 17/18 two-bit motor select
// - Code 19 inhibits transistors in front-end mode
// - Code 20 mains contactor confirmation
// - Code 24 requests coasting stop
// - Code 26 torque mode, else speed
// - Code 28 forces torque setpoint zero
// - Auto-run bit gates run at power-up
`timescale 1ns/1ps
`include "dfr_defs.svh"

module dfr_router #(
    parameter int NTERM = 8             // Number of input terminals
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    // Avalon-MM slave
    input  wire logic [5:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [3:0]           avs_byteenable,
    input  wire logic [31:0]          avs_writedata,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    // Terminal pins and mode
    input  wire logic [NTERM-1:0]     input_terminal,
    input  wire logic                 active_front_end_mode,
    // Command outputs
    output dfr_pkg::dfr_cmd_t         cmd,
    output logic                      run_hold
);

    // ==========================================
    // Decode helpers
    // One-hot of a selector code
    function automatic logic [63:0] code_hot(input dfr_pkg::dfr_sel_t c);
        code_hot    = '0;
        code_hot[c] = 1'b1;
    endfunction

    // Reset value of a selector by terminal index
    function automatic dfr_pkg::dfr_sel_t sel_rst(input int idx);
        case (idx)
            0:       sel_rst = `DFR_SEL_RST0;
            1:       sel_rst = `DFR_SEL_RST1;
            2:       sel_rst = `DFR_SEL_RST2;
            3:       sel_rst = `DFR_SEL_RST3;
            4:       sel_rst = `DFR_SEL_RST4;
            5:       sel_rst = `DFR_SEL_RST5;
            default: sel_rst = `DFR_SEL_RSTX;
        endcase
    endfunction

    // ==========================================
    // Registers and state
    dfr_pkg::dfr_sel_t  sel [NTERM];    // Function selectors
    logic               autostart;      // Power-up auto-run enable
    logic [NTERM-1:0]   sync1;          // First sync stage
    logic [NTERM-1:0]   sync2;          // Second sync stage
    logic [NTERM-1:0]   sync3;          // Third sync stage
    logic [NTERM-1:0]   filt;           // Agreed terminal levels
    logic [2:0]         settle;         // Cycles since reset
    logic               ack;            // Bus answer phase
    dfr_pkg::dfr_cmd_t  next_cmd;       // Command before register
    logic               next_run_hold;  // Next hold state
    logic [63:0]        hi_hit;         // Codes seen at high level
    logic [63:0]        lo_hit;         // Codes seen at low level

    // ==========================================
    // Bus decode
    wire        req      = avs_read | avs_write;
    wire        in_sel   = (avs_address[5] == 1'b0);
    wire [2:0]  sel_idx  = avs_address[4:2];
    wire        wr_go    = avs_write & ack & avs_byteenable[0];
    wire        code_ok  = (avs_writedata[5:0] <= `DFR_CODE_MAX);
    wire        wr_auto  = wr_go & (avs_address == `DFR_OFS_AUTO);
    wire        settled  = (settle == `DFR_SETTLE_CYC);
    wire        run_raw  = hi_hit[`DFR_C_FWD] | hi_hit[`DFR_C_REV];

    // Wait one cycle, then answer
    assign avs_waitrequest = req & ~ack;

    // Answer phase flag
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            ack <= 1'b0;
        else
            ack <= req & ~ack;
    end

    // ==========================================
    // Selector registers
    for (genvar t = 0; t < NTERM; t++)
    begin : g_sel
        // Write only legal codes; others keep old value
        wire hit_t = wr_go & in_sel & (sel_idx == 3'(t)) & code_ok;
        always_ff @(posedge clock)
        begin
            if (sys_rst)
                sel[t] <= sel_rst(t);
            else if (hit_t)
                sel[t] <= avs_writedata[5:0];
        end
    end

    // Auto-run enable register
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            autostart <= `DFR_AUTO_RST;
        else if (wr_auto)
            autostart <= avs_writedata[0];
    end

    // ==========================================
    // Read data mux, registered at the answer
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            avs_readdata <= '0;
        else if (avs_read & ~ack)
        begin
            if (in_sel)
                avs_readdata <= {26'h0, sel[sel_idx]};
            else if (avs_address == `DFR_OFS_AUTO)
                avs_readdata <= {31'h0, autostart};
            else if (avs_address == `DFR_OFS_PINS)
                avs_readdata <= {24'h0, 8'(filt)};
            else if (avs_address == `DFR_OFS_CMD)
                avs_readdata <= {10'h0, run_hold, cmd};
            else
                avs_readdata <= '0;                          // Unmapped
        end
    end

    // ==========================================
    // Terminal synchroniser and agreement filter
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end
        else
        begin
            sync1 <= input_terminal;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Take a bit only when stages two and three agree
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            filt <= '0;
        else
            filt <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
    end

    // Settle counter after reset
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            settle <= '0;
        else if (!settled)
            settle <= settle + 3'h1;
    end

    // ==========================================
    // Function hit vectors per level
    always_comb
    begin
        hi_hit = '0;
        lo_hit = '0;
        for (int i = 0; i < NTERM; i++)
        begin
            if (filt[i])
                hi_hit = hi_hit | code_hot(sel[i]);
            else
                lo_hit = lo_hit | code_hot(sel[i]);
        end
    end

    // ==========================================
    // Power-up run hold
    // Held from reset until settled with run absent or auto-run allowed
    assign next_run_hold = run_hold & ~(settled & (~run_raw | autostart));

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            run_hold <= 1'b1;
        else
            run_hold <= next_run_hold;
    end

    // ==========================================
    // Command mapping; code 0 and reserved bits are never read
    assign next_cmd.run_fwd        = hi_hit[`DFR_C_FWD] & ~run_hold;
    assign next_cmd.run_rev        = hi_hit[`DFR_C_REV] & ~run_hold;
    assign next_cmd.drive_enable   = hi_hit[`DFR_C_EN_HI]
                                   | lo_hit[`DFR_C_EN_LO];
    assign next_cmd.fault_reset    = hi_hit[`DFR_C_FRST];
    assign next_cmd.speed_step     = {hi_hit[`DFR_C_STEP3],
                                      hi_hit[`DFR_C_STEP2],
                                      hi_hit[`DFR_C_STEP1],
                                      hi_hit[`DFR_C_STEP0]};
    assign next_cmd.hook_mode      = hi_hit[`DFR_C_HOOK];
    assign next_cmd.dir_switch     = hi_hit[`DFR_C_DIR];
    assign next_cmd.estop_remote   = hi_hit[`DFR_C_REM_HI]
                                   | hi_hit[`DFR_C_REM2_HI]
                                   | lo_hit[`DFR_C_REM_LO];
    assign next_cmd.estop_local    = lo_hit[`DFR_C_LOC_LO];
    assign next_cmd.follower_ready = hi_hit[`DFR_C_FOLLOW];
    assign next_cmd.motor_sel      = {hi_hit[`DFR_C_MSEL1],
                                      hi_hit[`DFR_C_MSEL0]};
    assign next_cmd.pt_inhibit     = hi_hit[`DFR_C_PASSIVE]
                                   & active_front_end_mode;
    assign next_cmd.mains_confirm  = hi_hit[`DFR_C_MAINS];
    assign next_cmd.brake_feedback = hi_hit[`DFR_C_BRAKE];
    assign next_cmd.free_run_stop  = hi_hit[`DFR_C_COAST];
    assign next_cmd.force_control  = hi_hit[`DFR_C_FORCE];
    assign next_cmd.torque_zero    = hi_hit[`DFR_C_TZERO];

    // Command register
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            cmd <= '0;
        else
            cmd <= next_cmd;
    end

    // ==========================================
    // Assertions
    wire all_zero = (sel[0] == 6'h00) && (sel[1] == 6'h00)
                 && (sel[2] == 6'h00) && (sel[3] == 6'h00)
                 && (sel[4] == 6'h00) && (sel[5] == 6'h00)
                 && (sel[6] == 6'h00) && (sel[7] == 6'h00);
    wire rest_zero = (sel[1] == 6'h00) && (sel[2] == 6'h00)
                 && (sel[3] == 6'h00) && (sel[4] == 6'h00)
                 && (sel[5] == 6'h00) && (sel[6] == 6'h00)
                 && (sel[7] == 6'h00);

    property p_rst_defaults;
        @(posedge clock) $fell(sys_rst) |->
            sel[0] == `DFR_SEL_RST0 && sel[2] == `DFR_SEL_RST2 && sel[7] == `DFR_SEL_RSTX;
    endproperty
    a_rst_defaults: assert property (p_rst_defaults)
        else $error("selector reset value wrong");

    property p_bad_code;
        @(posedge clock) disable iff (sys_rst)
        (wr_go && avs_address == `DFR_OFS_SEL0 && avs_writedata[5:0] > `DFR_CODE_MAX)
            |=> $stable(sel[0]);
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("out of range code was stored");

    property p_zero_quiet;
        @(posedge clock) disable iff (sys_rst)
        all_zero [*2] |=> cmd == '0;
    endproperty
    a_zero_quiet: assert property (p_zero_quiet)
        else $error("code 0 drove a command");

    property p_reserved;
        @(posedge clock) disable iff (sys_rst)
        (rest_zero && (sel[0] == 6'h15 || sel[0] == 6'h1D)) [*2]
            |=> cmd == '0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code drove a command");

    property p_fwd;
        @(posedge clock) disable iff (sys_rst)
        (sel[0] == 6'h01 && filt[0] && !run_hold) |=> cmd.run_fwd;
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("forward run missing");

    property p_en_low;
        @(posedge clock) disable iff (sys_rst)
        (sel[0] == 6'h04 && !filt[0]) |=> cmd.drive_enable;
    endproperty
    a_en_low: assert property (p_en_low)
        else $error("low-active enable missing");

    property p_en_high;
        @(posedge clock) disable iff (sys_rst)
        (sel[0] == `DFR_C_EN_HI && filt[0]) |=> cmd.drive_enable;
    endproperty
    a_en_high: assert property (p_en_high)
        else $error("high-active enable missing");

    property p_fault_reset;
        @(posedge clock) disable iff (sys_rst)
        (sel[0] == `DFR_C_FRST && filt[0]) |=> cmd.fault_reset;
    endproperty
    a_fault_reset: assert property (p_fault_reset)
        else $error("fault reset request missing");

    property p_hook;
        @(posedge clock) disable iff (sys_rst)
        (sel[0] == `DFR_C_HOOK && filt[0]) |=> cmd.hook_mode;
    endproperty
    a_hook: assert property (p_hook)
        else $error("hook mode missing");

    property p_local_stop;
        @(posedge clock) disable iff (sys_rst)
        (sel[0] == 6'h0D && !filt[0]) |=> cmd.estop_local;
    endproperty
    a_local_stop: assert property (p_local_stop)
        else $error("local emergency missing");

    property p_remote_low;
        @(posedge clock) disable iff (sys_rst)
        (sel[0] == `DFR_C_REM_LO && !filt[0]) |=> cmd.estop_remote;
    endproperty
    a_remote_low: assert property (p_remote_low)
        else $error("low-active remote emergency missing");

    property p_shared_coast;
        @(posedge clock) disable iff (sys_rst)
        ((sel[2] == `DFR_C_COAST && filt[2]) || (sel[3] == `DFR_C_COAST && filt[3]))
            |=> cmd.free_run_stop;
    endproperty
    a_shared_coast: assert property (p_shared_coast)
        else $error("shared coasting stop not combined");

    property p_motor;
        @(posedge clock) disable iff (sys_rst)
        (rest_zero && sel[0] == 6'h11 && filt[0]) |=> cmd.motor_sel == 2'h1;
    endproperty
    a_motor: assert property (p_motor)
        else $error("motor select wrong");

    property p_inhibit;
        @(posedge clock) disable iff (sys_rst)
        !active_front_end_mode |=> !cmd.pt_inhibit;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("inhibit outside front-end mode");

    property p_hold_gate;
        @(posedge clock) disable iff (sys_rst)
        run_hold |=> !cmd.run_fwd && !cmd.run_rev;
    endproperty
    a_hold_gate: assert property (p_hold_gate)
        else $error("run passed during power-up hold");

    property p_wait;
        @(posedge clock) disable iff (sys_rst)
        avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait)
        else $error("waitrequest longer than one cycle");

endmodule

//--- tb/dfr_contacts.sv
// Purpose: Switch contact bank that drives the eight input terminals
// Assumes: Contacts move just after a rising clock edge
// Notes:   Bounce makes a one-cycle chatter on a single contact
`timescale 1ns/1ps

module dfr_contacts (
    // Clock
    input  wire logic        clock,
    // Terminal pins, high means closed to common return
    output logic [7:0]       input_terminal
);
    // ==========================================
    // Contact state
    // All contacts open at power-up
    initial input_terminal = 8'h00;

    // Move all contacts after the next edge
    task automatic set_levels(input logic [7:0] lv);
        @(posedge clock);
        input_terminal <= lv;
    endtask

    // Chatter: contact k flips for one cycle only
    task automatic bounce(input int k);
        @(posedge clock);
        input_terminal[k] <= ~input_terminal[k];
        @(posedge clock);
        input_terminal[k] <= ~input_terminal[k];
    endtask
endmodule

//--- tb/digital_input_function_router_bench.sv
// Purpose: Self-checking bench for the input terminal router
// Assumes: One wait cycle per bus access, five edges pin to command
// Notes:   Settle waits are longer than the pin latency on purpose
`timescale 1ns/1ps
`include "dfr_defs.svh"

module digital_input_function_router_bench;
    // ==========================================
    // Stimulus and observation
    logic              clock;                 // 250 MHz clock
    logic              sys_rst;               // Synchronous reset
    logic [5:0]        avs_address;           // Bus address
    logic              avs_read;              // Read strobe
    logic              avs_write;             // Write strobe
    logic [3:0]        avs_byteenable;        // Byte lanes
    logic [31:0]       avs_writedata;         // Write data
    logic [31:0]       avs_readdata;          // Read data
    logic              avs_waitrequest;       // Slave stall
    logic [7:0]        input_terminal;        // Terminal pins
    logic              afe_mode;              // Front-end mode
    dfr_pkg::dfr_cmd_t cmd;                   // Command outputs
    logic              run_hold;              // Power-up hold
    logic [31:0]       rd;                    // Last read word
    dfr_pkg::dfr_cmd_t e;                     // Expected commands
    int                errors = 0;            // Mismatch count
    int                n_compared = 0;        // Compare count

    // ==========================================
    // Design and contact bank
    dfr_router dfr_router_i (
        .clock                 (clock),
        .sys_rst               (sys_rst),
        .avs_address           (avs_address),
        .avs_read              (avs_read),
        .avs_write             (avs_write),
        .avs_byteenable        (avs_byteenable),
        .avs_writedata         (avs_writedata),
        .avs_readdata          (avs_readdata),
        .avs_waitrequest       (avs_waitrequest),
        .input_terminal        (input_terminal),
        .active_front_end_mode (afe_mode),
        .cmd                   (cmd),
        .run_hold              (run_hold)
    );
    dfr_contacts dfr_contacts_i (
        .clock          (clock),
        .input_terminal (input_terminal)
    );

    // Clock generator
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ==========================================
    // Tasks
    // Verdict and end of run
    task automatic end_of_test;
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus access, held until waitrequest is seen low
    task automatic bus(input logic is_wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address   <= a;
        avs_write     <= is_wr;
        avs_read      <= ~is_wr;
        avs_writedata <= d;
        // Only the watchdog ends a wait that never gets an answer
        do
            @(posedge clock);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Read and compare
    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // Wait past the pin-to-command latency
    task automatic settle;
        repeat (10) @(posedge clock);
    endtask

    // Selector address of terminal t
    function automatic logic [5:0] sel_a(input int t);
        return `DFR_OFS_SEL0 + 6'(4 * t);
    endfunction

    // Commands expected from one terminal with code c at level lv
    function automatic dfr_pkg::dfr_cmd_t exp_cmd(input int c, input logic lv, input logic afe);
        dfr_pkg::dfr_cmd_t x;
        x = '0;
        case (c)
            1:       x.run_fwd = lv;
            2:       x.run_rev = lv;
            3:       x.drive_enable = lv;
            4:       x.drive_enable = ~lv;       // Enable on open contact
            5:       x.fault_reset = lv;
            6, 7, 8, 9: x.speed_step[c-6] = lv;
            10:      x.hook_mode = lv;
            11:      x.dir_switch = lv;
            12, 14:  x.estop_remote = lv;
            15:      x.estop_remote = ~lv;       // Stop on open contact
            13:      x.estop_local = ~lv;        // Stop on open contact
            16:      x.follower_ready = lv;
            17:      x.motor_sel[0] = lv;
            18:      x.motor_sel[1] = lv;
            19:      x.pt_inhibit = lv & afe;    // Only in front-end mode
            20:      x.mains_confirm = lv;
            22:      x.brake_feedback = lv;
            24:      x.free_run_stop = lv;
            26:      x.force_control = lv;
            28:      x.torque_zero = lv;
            default: x = '0;                     // Unused and reserved codes
        endcase
        return x;
    endfunction

    // ==========================================
    // Watchdog against a hung access
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        end_of_test;
    end

    // ==========================================
    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'hF;
        afe_mode = 1'b0;
        dfr_contacts_i.set_levels(8'h01);        // Forward held at power-up
        repeat (15) @(posedge clock);
        chk({10'h000, run_hold, cmd}, 32'h0020_0000);
        sys_rst <= 1'b0;
        settle;
        chk({30'h0, run_hold, cmd.run_fwd}, 32'h2);
        rchk(`DFR_OFS_CMD, 32'h0020_0000);
        rchk(`DFR_OFS_AUTO, 32'h0);
        for (int t = 0; t < 8; t++)
            rchk(sel_a(t), t < 6 ? 32'({8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h08} >> (8 * (5 - t))) & 32'hFF : 32'h0);
        bus(1'b1, `DFR_OFS_AUTO, 32'h1);
        settle;
        chk({30'h0, run_hold, cmd.run_fwd}, 32'h1);
        rchk(`DFR_OFS_AUTO, 32'h1);
        // Out-of-range code, lane-gated write, unmapped and status places
        bus(1'b1, sel_a(0), 32'h21);
        rchk(sel_a(0), 32'h1);
        bus(1'b1, sel_a(0), 32'h20);
        rchk(sel_a(0), 32'h20);
        @(posedge clock);
        avs_byteenable <= 4'h0;
        bus(1'b1, sel_a(0), 32'h5);
        avs_byteenable <= 4'hF;
        rchk(sel_a(0), 32'h20);
        bus(1'b1, 6'h30, 32'h1F);
        rchk(6'h30, 32'h0);
        dfr_contacts_i.set_levels(8'hA5);
        settle;
        rchk(`DFR_OFS_PINS, 32'hA5);
        bus(1'b1, `DFR_OFS_PINS, 32'h0);
        rchk(`DFR_OFS_PINS, 32'hA5);
        // Every code on terminal 0, both levels, both front-end modes
        for (int t = 1; t < 8; t++)
            bus(1'b1, sel_a(t), 32'h0);
        dfr_contacts_i.set_levels(8'h00);
        for (int a = 0; a < 2; a++)
        begin
            @(posedge clock);
            afe_mode <= a[0];
            for (int c = 0; c <= 32; c++)
            begin
                bus(1'b1, sel_a(0), 32'(c));
                dfr_contacts_i.set_levels(8'h01);
                settle;
                e = exp_cmd(c, 1'b1, a[0]);
                chk({11'h000, cmd}, {11'h000, e});
                rchk(`DFR_OFS_CMD, {11'h000, e});
                dfr_contacts_i.set_levels(8'h00);
                settle;
                e = exp_cmd(c, 1'b0, a[0]);
                chk({11'h000, cmd}, {11'h000, e});
            end
        end
        // Motor select bits and a function shared by two terminals
        bus(1'b1, sel_a(0), 32'd17);
        bus(1'b1, sel_a(1), 32'd18);
        bus(1'b1, sel_a(2), 32'd24);
        bus(1'b1, sel_a(3), 32'd24);
        for (int p = 0; p < 16; p++)
        begin
            dfr_contacts_i.set_levels(8'(p));
            settle;
            e = '0;
            e.motor_sel = 2'(p);
            e.free_run_stop = p[2] | p[3];
            chk({11'h000, cmd}, {11'h000, e});
        end
        // A one-cycle chatter must not reach the commands
        dfr_contacts_i.set_levels(8'h00);
        settle;
        dfr_contacts_i.bounce(2);
        repeat (6) @(posedge clock);
        chk({11'h000, cmd}, 32'h0);
        end_of_test;
    end
endmodule
